// File: verilog/bencs_defines.svh
`ifndef BENCS_DEFINES_SVH
`define BENCS_DEFINES_SVH
`define BENCS_IDX_CTL 16'hF0D9
`define BENCS_IDX_STAT 16'hF0DA
`define BENCS_IDX_SSEL 16'h2000
`define BENCS_WIN_FB 4'h0
`define BENCS_WIN_ECC 4'h1
`define BENCS_FB_DEPTH 12'hBDF
`define BENCS_ECC_DEPTH 8'hA0
`define BENCS_CTL_RST 0
`define BENCS_CTL_SHARE 5
`define BENCS_CTL_HDR 6
`define BENCS_CTL_SUB 7
`define BENCS_CTL_WMASK 8'hE1
`define BENCS_CTL_RESET 8'h00
`define BENCS_SSEL_RESET 2'h3
`define BENCS_ST_EOF 0
`define BENCS_ST_ACK 3
`define BENCS_ST_ACKF 4
`define BENCS_ST_SYS 5
`define BENCS_ST_COM 6
`define BENCS_ST_CMB 7
`define BENCS_FB_SYNC_B 12'h000
`define BENCS_FB_SYNC_L 12'h00C
`define BENCS_FB_HDR_B 12'h00C
`define BENCS_FB_QUAD_L 12'h004
`define BENCS_FB_DATA_B 12'h010
`define BENCS_FB_DATA_L 12'h800
`define BENCS_FB_CRCP_B 12'h810
`define BENCS_FB_PAD_B 12'h814
`define BENCS_FB_PAD_L 12'h008
`define BENCS_FB_PPAR_B 12'h81C
`define BENCS_FB_P_L 12'h0AC
`define BENCS_FB_QPAR_B 12'h8C8
`define BENCS_FB_Q_L 12'h068
`define BENCS_FB_QCH_B 12'h930
`define BENCS_FB_QCH_L 12'h010
`define BENCS_FB_SUBCH_B 12'h940
`define BENCS_FB_SUBCH_L 12'h060
`define BENCS_FB_FLAGS_B 12'h9A0
`define BENCS_FB_FLAGS_L 12'h126
`define BENCS_FB_CREM_B 12'hAC6
`define BENCS_FB_PSYN_B 12'hACA
`define BENCS_FB_QSYN_B 12'hB76
`define BENCS_FB_STAT_B 12'hBDE
`define BENCS_FB_STAT_L 12'h001
`define BENCS_ECC_PSYN_N 8'h56
`define BENCS_ECC_QSYN_N 8'h34
`define BENCS_ECC_FLAG_N 9'h126
`define BENCS_ECC_FLAG_SPLIT 9'h044
`define BENCS_ECC_QUAD_N 9'h004
`define BENCS_ECC_EREG_N 9'h03C
`define BENCS_ECC_W_FLAG0 8'h34
`define BENCS_ECC_W_FLAG1 8'h56
`define BENCS_ECC_W_CRC 8'h8F
`define BENCS_ECC_W_HDR 8'h90
`define BENCS_ECC_W_EREG 8'h91
`endif

// File: verilog/bencs_pkg.sv
package bencs_pkg;
	typedef enum logic [3:0] {
		FB_SYNC, FB_HDR, FB_SUBHDR, FB_DATA, FB_CRCP, FB_PAD, FB_PPAR, FB_QPAR,
		FB_QCH, FB_SUBCH, FB_FLAGS, FB_CREM, FB_PSYN, FB_QSYN, FB_STAT
	} bencs_fb_field_t;
	typedef enum logic [2:0] {
		ECC_PSYN, ECC_QSYN, ECC_FLAGS, ECC_CRC, ECC_HDR, ECC_EREG
	} bencs_ecc_field_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_RESP = 2'b10
	} bencs_state_t;
endpackage : bencs_pkg

// File: verilog/bencs_mem.sv
module bencs_mem #(
	parameter int NB = 1,
	parameter int AW = 12,
	parameter int DEPTH = 3039
) (
	input wire logic clk_in,
	input wire logic ce_in,
	input wire logic re_in,
	input wire logic [NB-1:0] we_in,
	input wire logic [AW-1:0] addr_in,
	input wire logic [8*NB-1:0] wdata_in,
	output logic [8*NB-1:0] rdata_out
);
	logic [8*NB-1:0] mem_q [DEPTH];
	logic [8*NB-1:0] rdata_q;

	// Read data held in a register until the next read
	always_ff @(posedge clk_in) begin
		if (ce_in && re_in) begin
			rdata_q <= mem_q[addr_in];
		end
	end

	// One write lane per byte; one process owns the whole array
	always_ff @(posedge clk_in) begin
		if (ce_in) begin
			for (int g = 0; g < NB; g++) begin
				if (we_in[g]) begin
					mem_q[addr_in][8*g +: 8] <= wdata_in[8*g +: 8];
				end
			end
		end
	end

	assign rdata_out = rdata_q;
endmodule : bencs_mem

// File: verilog/bencs_top.sv
// Implementation choice: the APB slave port.
`include "bencs_defines.svh"

// How it works
// - Share bit grants encoder ECC RAM writes outside encoder reset
// - Header byte from encoder or host input
// - Sub-header byte from encoder or host input
// - Control bits 7,6,5 and 0
// - Status bit 0 latches end of frame outside encoder reset
// - Status bit 3 live ack; fall pulses
// - Status bit 4 latches ack falling edge
// - Status bits 5,6 show sync inputs
// - Status bit 7 selected sync combination
// - Sync field then four header bytes
// - 2048 data bytes at 0x010
// - CRC parity then eight padding bytes
// - P parity then Q parity
// - Q channel then sub-channel bytes
// - 294 error flag bytes at 0x9A0
// - CRC remainder at 0xAC6
// - P syndromes then Q syndromes
// - Single status byte at 0xBDE
// - ECC words 0-51 hold P/Q syndromes
// - Words 52-85 P syndromes and flags, then flags
// - CRC remainder word, then header word
// - ECC work registers four per word
module bencs_top (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic ce_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [17:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic enc_fb_we_in,
	input wire bencs_pkg::bencs_fb_field_t enc_fb_field_in,
	input wire logic [11:0] enc_fb_index_in,
	input wire logic [7:0] enc_fb_data_in,
	input wire logic enc_ecc_we_in,
	input wire bencs_pkg::bencs_ecc_field_t enc_ecc_field_in,
	input wire logic [8:0] enc_ecc_index_in,
	input wire logic [7:0] enc_ecc_data_in,
	input wire logic [31:0] host_header_in,
	input wire logic [31:0] host_subheader_in,
	input wire logic frame_end_in,
	input wire logic engine_byte_ack_in,
	input wire logic system_sync_in,
	input wire logic link_sync_in,
	output logic encoder_reset_out,
	output logic ecc_ram_grant_out,
	output logic header_source_select_out,
	output logic subheader_source_select_out,
	output logic ack_ready_pulse_out
);
	import bencs_pkg::*;

	function automatic logic [11:0] fb_base(input bencs_fb_field_t f);
		unique case (f)
			FB_SYNC: fb_base = `BENCS_FB_SYNC_B;
			FB_HDR: fb_base = `BENCS_FB_HDR_B;
			FB_SUBHDR: fb_base = `BENCS_FB_DATA_B;
			FB_DATA: fb_base = `BENCS_FB_DATA_B;
			FB_CRCP: fb_base = `BENCS_FB_CRCP_B;
			FB_PAD: fb_base = `BENCS_FB_PAD_B;
			FB_PPAR: fb_base = `BENCS_FB_PPAR_B;
			FB_QPAR: fb_base = `BENCS_FB_QPAR_B;
			FB_QCH: fb_base = `BENCS_FB_QCH_B;
			FB_SUBCH: fb_base = `BENCS_FB_SUBCH_B;
			FB_FLAGS: fb_base = `BENCS_FB_FLAGS_B;
			FB_CREM: fb_base = `BENCS_FB_CREM_B;
			FB_PSYN: fb_base = `BENCS_FB_PSYN_B;
			FB_QSYN: fb_base = `BENCS_FB_QSYN_B;
			FB_STAT: fb_base = `BENCS_FB_STAT_B;
			default: fb_base = `BENCS_FB_SYNC_B;
		endcase
	endfunction : fb_base

	function automatic logic [11:0] fb_len(input bencs_fb_field_t f);
		unique case (f)
			FB_SYNC: fb_len = `BENCS_FB_SYNC_L;
			FB_HDR, FB_SUBHDR, FB_CRCP, FB_CREM: fb_len = `BENCS_FB_QUAD_L;
			FB_DATA: fb_len = `BENCS_FB_DATA_L;
			FB_PAD: fb_len = `BENCS_FB_PAD_L;
			FB_PPAR, FB_PSYN: fb_len = `BENCS_FB_P_L;
			FB_QPAR, FB_QSYN: fb_len = `BENCS_FB_Q_L;
			FB_QCH: fb_len = `BENCS_FB_QCH_L;
			FB_SUBCH: fb_len = `BENCS_FB_SUBCH_L;
			FB_FLAGS: fb_len = `BENCS_FB_FLAGS_L;
			FB_STAT: fb_len = `BENCS_FB_STAT_L;
			default: fb_len = 12'h000;
		endcase
	endfunction : fb_len

	// Returns {valid, word, byte lane}
	function automatic logic [10:0] ecc_loc(input bencs_ecc_field_t f, input logic [8:0] i);
		logic [8:0] k;
		logic ok;
		logic [7:0] w;
		logic [1:0] ln;
		k = i - `BENCS_ECC_FLAG_SPLIT;
		ok = 1'b0;
		w = 8'h00;
		ln = i[1:0];
		unique case (f)
			ECC_PSYN: begin
				ok = i[8:1] < `BENCS_ECC_PSYN_N;
				w = i[8:1];
				ln = {1'b1, i[0]};
			end
			ECC_QSYN: begin
				ok = i[8:1] < `BENCS_ECC_QSYN_N;
				w = i[8:1];
				ln = {1'b0, i[0]};
			end
			ECC_FLAGS: begin
				ok = i < `BENCS_ECC_FLAG_N;
				if (i < `BENCS_ECC_FLAG_SPLIT) begin
					w = `BENCS_ECC_W_FLAG0 + i[8:1];
					ln = {1'b0, i[0]};
				end else begin
					w = `BENCS_ECC_W_FLAG1 + k[8:2];
					ln = k[1:0];
				end
			end
			ECC_CRC: begin
				ok = i < `BENCS_ECC_QUAD_N;
				w = `BENCS_ECC_W_CRC;
			end
			ECC_HDR: begin
				ok = i < `BENCS_ECC_QUAD_N;
				w = `BENCS_ECC_W_HDR;
			end
			ECC_EREG: begin
				ok = i < `BENCS_ECC_EREG_N;
				w = `BENCS_ECC_W_EREG + i[8:2];
			end
			default: ok = 1'b0;
		endcase
		return {ok, w, ln};
	endfunction : ecc_loc

	function automatic logic [7:0] pick_byte(input logic host, input logic [31:0] hv,
			input logic [1:0] idx, input logic [7:0] ev);
		return host ? hv[{idx, 3'b000} +: 8] : ev;
	endfunction : pick_byte

	bencs_state_t state_q, state_d;
	logic [7:0] ctl_q, ctl_d;
	logic [1:0] ssel_q, ssel_d;
	logic eof_q, eof_d;
	logic ackf_q, ackf_d;
	logic ack_prev_q, ack_prev_d;
	logic ack_pulse_q, ack_pulse_d;
	logic [31:0] prdata_q, prdata_d;
	logic in_reset, apb_go, ack_fall;
	logic sel_ctl, sel_stat, sel_ssel, sel_fb, sel_ecc, mapped, mem_busy;
	logic wr_fire, rd_fire;
	logic [7:0] status_v;
	logic enc_fb_hit, enc_ecc_hit;
	logic [11:0] enc_fb_addr;
	logic [7:0] enc_fb_byte, enc_ecc_byte;
	logic [10:0] enc_ecc_loc;
	logic fb_re, ecc_re;
	logic fb_we;
	logic [11:0] fb_addr;
	logic [7:0] fb_wdata, fb_rdata;
	logic [3:0] ecc_we;
	logic [7:0] ecc_addr;
	logic [31:0] ecc_wdata, ecc_rdata;

	always_comb begin
		in_reset = ctl_q[`BENCS_CTL_RST];
		apb_go = psel_in && penable_in;
		ack_fall = ack_prev_q && !engine_byte_ack_in;
		sel_ctl = paddr_in == {`BENCS_IDX_CTL, 2'b00};
		sel_stat = paddr_in == {`BENCS_IDX_STAT, 2'b00};
		sel_ssel = paddr_in == {`BENCS_IDX_SSEL, 2'b00};
		sel_fb = paddr_in[17:14] == `BENCS_WIN_FB && paddr_in[1:0] == 2'b00
			&& paddr_in[13:2] < `BENCS_FB_DEPTH;
		sel_ecc = paddr_in[17:14] == `BENCS_WIN_ECC && paddr_in[1:0] == 2'b00
			&& paddr_in[13:10] == 4'h0 && paddr_in[9:2] < `BENCS_ECC_DEPTH;
		mapped = sel_ctl || sel_stat || sel_ssel || sel_fb || sel_ecc;
		// Encoder side of the frame buffer
		enc_fb_addr = fb_base(enc_fb_field_in) + enc_fb_index_in;
		enc_fb_hit = enc_fb_we_in && !in_reset
			&& enc_fb_index_in < fb_len(enc_fb_field_in);
		enc_fb_byte = enc_fb_data_in;
		if (enc_fb_field_in == FB_HDR) begin
			enc_fb_byte = pick_byte(ctl_q[`BENCS_CTL_HDR], host_header_in,
				enc_fb_index_in[1:0], enc_fb_data_in);
		end else if (enc_fb_field_in == FB_SUBHDR) begin
			enc_fb_byte = pick_byte(ctl_q[`BENCS_CTL_SUB], host_subheader_in,
				enc_fb_index_in[1:0], enc_fb_data_in);
		end
		// Encoder side of the ECC RAM
		enc_ecc_loc = ecc_loc(enc_ecc_field_in, enc_ecc_index_in);
		enc_ecc_hit = enc_ecc_we_in && ecc_ram_grant_out && enc_ecc_loc[10];
		enc_ecc_byte = enc_ecc_data_in;
		if (enc_ecc_field_in == ECC_HDR) begin
			enc_ecc_byte = pick_byte(ctl_q[`BENCS_CTL_HDR], host_header_in,
				enc_ecc_index_in[1:0], enc_ecc_data_in);
		end
		// Encoder always wins; the bus waits
		mem_busy = (sel_fb && enc_fb_hit) || (sel_ecc && enc_ecc_hit);
		pready_out = ce_in && state_q == ST_RESP && !(pwrite_in && mem_busy);
		pslverr_out = pready_out && (!mapped || (pwrite_in && sel_stat));
		wr_fire = pready_out && pwrite_in;
		rd_fire = pready_out && !pwrite_in;
		prdata_out = prdata_q;
		if (sel_fb) begin
			prdata_out = {24'h00_0000, fb_rdata};
		end else if (sel_ecc) begin
			prdata_out = ecc_rdata;
		end
	end

	// Live status view
	always_comb begin
		status_v = 8'h00;
		status_v[`BENCS_ST_EOF] = eof_q;
		status_v[`BENCS_ST_ACK] = engine_byte_ack_in;
		status_v[`BENCS_ST_ACKF] = ackf_q;
		status_v[`BENCS_ST_SYS] = system_sync_in;
		status_v[`BENCS_ST_COM] = link_sync_in;
		status_v[`BENCS_ST_CMB] = (ssel_q[0] && system_sync_in)
			|| (ssel_q[1] && link_sync_in);
	end

	// Memory port steering
	always_comb begin
		fb_re = state_q == ST_IDLE && apb_go && !pwrite_in && sel_fb && !mem_busy;
		ecc_re = state_q == ST_IDLE && apb_go && !pwrite_in && sel_ecc && !mem_busy;
		fb_we = enc_fb_hit || (wr_fire && sel_fb);
		fb_addr = enc_fb_hit ? enc_fb_addr : paddr_in[13:2];
		fb_wdata = enc_fb_hit ? enc_fb_byte : pwdata_in[7:0];
		ecc_we = 4'h0;
		ecc_addr = paddr_in[9:2];
		ecc_wdata = pwdata_in;
		if (enc_ecc_hit) begin
			ecc_we = 4'h1 << enc_ecc_loc[1:0];
			ecc_addr = enc_ecc_loc[9:2];
			ecc_wdata = {4{enc_ecc_byte}};
		end else if (wr_fire && sel_ecc) begin
			ecc_we = 4'hF;
		end
	end

	// Next state of the bus engine and registers
	always_comb begin
		state_d = state_q;
		ctl_d = ctl_q;
		ssel_d = ssel_q;
		prdata_d = prdata_q;
		unique case (state_q)
			ST_IDLE: begin
				if (apb_go && !mem_busy) begin
					state_d = ST_RESP;
					prdata_d = 32'h0000_0000;
					if (sel_ctl) begin
						prdata_d[7:0] = ctl_q;
					end else if (sel_stat) begin
						prdata_d[7:0] = status_v;
					end else if (sel_ssel) begin
						prdata_d[1:0] = ssel_q;
					end
				end
			end
			ST_RESP: begin
				if (pready_out) begin
					state_d = ST_IDLE;
				end
			end
			default: state_d = ST_IDLE;
		endcase
		if (wr_fire && sel_ctl) begin
			ctl_d = pwdata_in[7:0] & `BENCS_CTL_WMASK;
		end
		if (wr_fire && sel_ssel) begin
			ssel_d = pwdata_in[1:0];
		end
		// Flags clear on status read only if they were seen; a new event wins
		eof_d = (eof_q && !(rd_fire && sel_stat && prdata_q[`BENCS_ST_EOF]))
			|| (frame_end_in && !in_reset);
		ackf_d = (ackf_q && !(rd_fire && sel_stat && prdata_q[`BENCS_ST_ACKF]))
			|| ack_fall;
		ack_prev_d = engine_byte_ack_in;
		ack_pulse_d = ack_fall;
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state_q <= ST_IDLE;
			ctl_q <= `BENCS_CTL_RESET;
			ssel_q <= `BENCS_SSEL_RESET;
			prdata_q <= 32'h0000_0000;
			eof_q <= 1'b0;
			ackf_q <= 1'b0;
			ack_prev_q <= 1'b0;
			ack_pulse_q <= 1'b0;
		end else if (ce_in) begin
			state_q <= state_d;
			ctl_q <= ctl_d;
			ssel_q <= ssel_d;
			prdata_q <= prdata_d;
			eof_q <= eof_d;
			ackf_q <= ackf_d;
			ack_prev_q <= ack_prev_d;
			ack_pulse_q <= ack_pulse_d;
		end
	end

	assign encoder_reset_out = ctl_q[`BENCS_CTL_RST];
	assign ecc_ram_grant_out = ctl_q[`BENCS_CTL_SHARE] && !ctl_q[`BENCS_CTL_RST];
	assign header_source_select_out = ctl_q[`BENCS_CTL_HDR];
	assign subheader_source_select_out = ctl_q[`BENCS_CTL_SUB];
	assign ack_ready_pulse_out = ack_pulse_q;

	bencs_mem #(.NB(1), .AW(12), .DEPTH(`BENCS_FB_DEPTH)) u_fb (
		.clk_in(clk_in),
		.ce_in(ce_in),
		.re_in(fb_re),
		.we_in(fb_we),
		.addr_in(fb_addr),
		.wdata_in(fb_wdata),
		.rdata_out(fb_rdata)
	);

	bencs_mem #(.NB(4), .AW(8), .DEPTH(`BENCS_ECC_DEPTH)) u_ecc (
		.clk_in(clk_in),
		.ce_in(ce_in),
		.re_in(ecc_re),
		.we_in(ecc_we),
		.addr_in(ecc_addr),
		.wdata_in(ecc_wdata),
		.rdata_out(ecc_rdata)
	);

	default clocking dc @(posedge clk_in); endclocking
	default disable iff (!resetn_in);

	property p_rst_set;
		(wr_fire && sel_ctl && pwdata_in[`BENCS_CTL_RST]) |=> encoder_reset_out && !enc_fb_hit;
	endproperty
	a_rst_set: assert property (p_rst_set) else $error("reset bit not taken");

	property p_rst_block;
		encoder_reset_out |-> !enc_fb_hit && !enc_ecc_hit && !ecc_ram_grant_out;
	endproperty
	a_rst_block: assert property (p_rst_block) else $error("encoder wrote in reset");

	property p_share;
		(enc_ecc_we_in && !ctl_q[`BENCS_CTL_SHARE] && !(wr_fire && sel_ecc)) |-> ecc_we == 4'h0;
	endproperty
	a_share: assert property (p_share) else $error("ECC write without share");

	property p_hdr;
		(enc_fb_hit && enc_fb_field_in == FB_HDR && header_source_select_out)
			|-> fb_wdata == host_header_in[{enc_fb_index_in[1:0], 3'b000} +: 8];
	endproperty
	a_hdr: assert property (p_hdr) else $error("header not from host");

	property p_sub;
		(enc_fb_hit && enc_fb_field_in == FB_SUBHDR && !subheader_source_select_out)
			|-> fb_wdata == enc_fb_data_in && fb_we;
	endproperty
	a_sub: assert property (p_sub) else $error("sub-header not from encoder");

	property p_eof;
		(ce_in && frame_end_in && !encoder_reset_out) |=> status_v[`BENCS_ST_EOF];
	endproperty
	a_eof: assert property (p_eof) else $error("end of frame lost");

	property p_ack;
		(ce_in && ack_prev_q && !engine_byte_ack_in)
			|=> ack_ready_pulse_out && status_v[`BENCS_ST_ACKF];
	endproperty
	a_ack: assert property (p_ack) else $error("ack edge missed");

	property p_sync;
		status_v[`BENCS_ST_SYS] == system_sync_in && status_v[`BENCS_ST_COM] == link_sync_in
			&& (ssel_q != 2'h0 || !status_v[`BENCS_ST_CMB]);
	endproperty
	a_sync: assert property (p_sync) else $error("sync status wrong");

	property p_fb_data;
		(enc_fb_hit && enc_fb_field_in == FB_DATA) |-> fb_addr == `BENCS_FB_DATA_B + enc_fb_index_in;
	endproperty
	a_fb_data: assert property (p_fb_data) else $error("frame data misplaced");

	property p_ecc_flag;
		(enc_ecc_hit && enc_ecc_field_in == ECC_FLAGS && enc_ecc_index_in == 9'h124)
			|-> ecc_addr == 8'h8E && ecc_we == 4'h1;
	endproperty
	a_ecc_flag: assert property (p_ecc_flag) else $error("flag 292 misplaced");
endmodule : bencs_top

// File: sim/bencs_engine_model.sv
module bencs_engine_model (
	input wire logic clk_in,
	output logic fb_we_out,
	output bencs_pkg::bencs_fb_field_t fb_field_out,
	output logic [11:0] fb_index_out,
	output logic [7:0] fb_data_out,
	output logic ecc_we_out,
	output bencs_pkg::bencs_ecc_field_t ecc_field_out,
	output logic [8:0] ecc_index_out,
	output logic [7:0] ecc_data_out,
	output logic frame_end_out,
	output logic byte_ack_out,
	output logic system_sync_out,
	output logic link_sync_out
);
	timeunit 1ns;
	timeprecision 1ps;
	import bencs_pkg::*;
	initial begin
		fb_we_out = 1'b0;
		fb_field_out = FB_SYNC;
		fb_index_out = 12'h000;
		fb_data_out = 8'h00;
		ecc_we_out = 1'b0;
		ecc_field_out = ECC_PSYN;
		ecc_index_out = 9'h000;
		ecc_data_out = 8'h00;
		frame_end_out = 1'b0;
		byte_ack_out = 1'b0;
		system_sync_out = 1'b0;
		link_sync_out = 1'b0;
	end
	// One byte per write; data line shows the inverse once released
	task automatic fb_write(input bencs_fb_field_t f, input logic [11:0] i, input logic [7:0] d);
		@(posedge clk_in);
		fb_we_out <= 1'b1;
		fb_field_out <= f;
		fb_index_out <= i;
		fb_data_out <= d;
		@(posedge clk_in);
		fb_we_out <= 1'b0;
		fb_data_out <= ~d;
	endtask : fb_write
	task automatic ecc_write(input bencs_ecc_field_t f, input logic [8:0] i, input logic [7:0] d);
		@(posedge clk_in);
		ecc_we_out <= 1'b1;
		ecc_field_out <= f;
		ecc_index_out <= i;
		ecc_data_out <= d;
		@(posedge clk_in);
		ecc_we_out <= 1'b0;
		ecc_data_out <= ~d;
	endtask : ecc_write
	task automatic eof_pulse;
		@(posedge clk_in);
		frame_end_out <= 1'b1;
		@(posedge clk_in);
		frame_end_out <= 1'b0;
	endtask : eof_pulse
	task automatic set_lines(input logic ack, input logic sys, input logic link);
		@(posedge clk_in);
		byte_ack_out <= ack;
		system_sync_out <= sys;
		link_sync_out <= link;
	endtask : set_lines
endmodule : bencs_engine_model

// File: sim/bencs_top_tb_top.sv
`include "bencs_defines.svh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin miscompares++; \
	$display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module bencs_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import bencs_pkg::*;
	localparam logic [17:0] A_CTL = {`BENCS_IDX_CTL, 2'b00};
	localparam logic [17:0] A_STAT = {`BENCS_IDX_STAT, 2'b00};
	localparam logic [17:0] A_SSEL = 18'h0_8000;
	logic clk_in = 1'b0;
	logic resetn_in = 1'b0;
	logic ce = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [17:0] paddr = 18'h0_0000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata_out;
	logic pready_out, pslverr_out, fb_we, ecc_we, eof, ack, sys, link;
	bencs_fb_field_t fb_f;
	bencs_ecc_field_t ecc_f;
	logic [11:0] fb_i;
	logic [8:0] ecc_i;
	logic [7:0] fb_d, ecc_d;
	logic [31:0] hh = 32'hA1B2_C3D4;
	logic [31:0] hs = 32'h5E6F_7081;
	logic rst_o, grant_o, hsel_o, ssel_o, pulse_o;
	int miscompares = 0;
	int n_compared = 0;
	int n_pulse = 0;
	logic [31:0] r;
	logic e;
	always #10 clk_in = ~clk_in;
	always @(posedge clk_in) if (pulse_o === 1'b1) n_pulse++;
	bencs_top dut_u (.clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce), .psel_in(psel),
		.penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
		.prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
		.enc_fb_we_in(fb_we), .enc_fb_field_in(fb_f), .enc_fb_index_in(fb_i),
		.enc_fb_data_in(fb_d), .enc_ecc_we_in(ecc_we), .enc_ecc_field_in(ecc_f),
		.enc_ecc_index_in(ecc_i), .enc_ecc_data_in(ecc_d), .host_header_in(hh),
		.host_subheader_in(hs), .frame_end_in(eof), .engine_byte_ack_in(ack),
		.system_sync_in(sys), .link_sync_in(link), .encoder_reset_out(rst_o),
		.ecc_ram_grant_out(grant_o), .header_source_select_out(hsel_o),
		.subheader_source_select_out(ssel_o), .ack_ready_pulse_out(pulse_o));
	bencs_engine_model eng_u (.clk_in(clk_in), .fb_we_out(fb_we), .fb_field_out(fb_f),
		.fb_index_out(fb_i), .fb_data_out(fb_d), .ecc_we_out(ecc_we), .ecc_field_out(ecc_f),
		.ecc_index_out(ecc_i), .ecc_data_out(ecc_d), .frame_end_out(eof),
		.byte_ack_out(ack), .system_sync_out(sys), .link_sync_out(link));
	task automatic close_out;
		$display("compared=%0d miscompares=%0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : close_out
	// Setup, then access held until pready is seen high at a rising edge, or for at most 50 edges
	task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_in);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_in);
		penable <= 1'b1;
		do begin
			@(posedge clk_in);
			n++;
		end while (pready_out !== 1'b1 && n < 50);
		r = prdata_out;
		e = pslverr_out;
		if (pready_out !== 1'b1) miscompares++;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic t_regs;
		apb(1'b0, A_CTL, 32'h0);
		`CHK(r, 32'h0000_0000)
		apb(1'b1, 18'h1_0000, 32'h0);
		`CHK(e, 1'b1)
		apb(1'b1, A_STAT, 32'hFF);
		`CHK(e, 1'b1)
		apb(1'b1, A_CTL, 32'hFF);
		apb(1'b0, A_CTL, 32'h0);
		`CHK(r, 32'h0000_00E1)
		`CHK({rst_o, grant_o, hsel_o, ssel_o}, 4'b1011)
		apb(1'b1, A_CTL, 32'h20);
		@(posedge clk_in);
		`CHK({rst_o, grant_o, hsel_o, ssel_o}, 4'b0100)
		$display("t_regs done");
	endtask : t_regs
	task automatic t_status;
		int p0;
		eng_u.set_lines(1'b1, 1'b1, 1'b0);
		p0 = n_pulse;
		eng_u.set_lines(1'b0, 1'b1, 1'b0);
		eng_u.eof_pulse();
		repeat (3) @(posedge clk_in);
		`CHK(n_pulse - p0, 1)
		apb(1'b0, A_STAT, 32'h0);
		`CHK(r[7:0], 8'hB1)
		apb(1'b0, A_STAT, 32'h0);
		`CHK(r[7:0], 8'hA0)
		apb(1'b1, A_SSEL, 32'h2);
		apb(1'b0, A_STAT, 32'h0);
		`CHK(r[7:0], 8'h20)
		eng_u.set_lines(1'b1, 1'b0, 1'b1);
		apb(1'b0, A_STAT, 32'h0);
		`CHK(r[7:0], 8'hC8)
		eng_u.set_lines(1'b0, 1'b0, 1'b0);
		apb(1'b0, A_STAT, 32'h0);
		`CHK(r[7:0], 8'h10)
		$display("t_status done");
	endtask : t_status
	task automatic fb_case(input bencs_fb_field_t f, input logic [11:0] i, input logic [11:0] k);
		logic [7:0] d;
		d = k[7:0] ^ 8'h5A;
		eng_u.fb_write(f, i, d);
		apb(1'b0, {4'h0, k, 2'b00}, 32'h0);
		`CHK(r[7:0], d)
	endtask : fb_case
	task automatic ecc_case(input bencs_ecc_field_t f, input logic [8:0] i, input logic [7:0] w,
		input int l);
		logic [7:0] d;
		d = w ^ 8'hC3;
		eng_u.ecc_write(f, i, d);
		apb(1'b0, 18'h0_4000 + {8'h00, w, 2'b00}, 32'h0);
		`CHK(r[8*l+:8], d)
	endtask : ecc_case
	task automatic t_maps;
		apb(1'b1, A_CTL, 32'h20);
		fb_case(FB_SYNC, 12'h00B, 12'h00B);
		fb_case(FB_HDR, 12'h000, 12'h00C);
		fb_case(FB_DATA, 12'h7FF, 12'h80F);
		fb_case(FB_CRCP, 12'h000, 12'h810);
		fb_case(FB_PAD, 12'h007, 12'h81B);
		fb_case(FB_PPAR, 12'h000, 12'h81C);
		fb_case(FB_QPAR, 12'h067, 12'h92F);
		fb_case(FB_QCH, 12'h000, 12'h930);
		fb_case(FB_SUBCH, 12'h05F, 12'h99F);
		fb_case(FB_FLAGS, 12'h125, 12'hAC5);
		fb_case(FB_CREM, 12'h003, 12'hAC9);
		fb_case(FB_PSYN, 12'h000, 12'hACA);
		fb_case(FB_QSYN, 12'h067, 12'hBDD);
		fb_case(FB_STAT, 12'h000, 12'hBDE);
		ecc_case(ECC_PSYN, 9'h000, 8'd0, 2);
		ecc_case(ECC_QSYN, 9'h001, 8'd0, 1);
		ecc_case(ECC_PSYN, 9'd103, 8'd51, 3);
		ecc_case(ECC_PSYN, 9'd104, 8'd52, 2);
		ecc_case(ECC_FLAGS, 9'd67, 8'd85, 1);
		ecc_case(ECC_FLAGS, 9'd68, 8'd86, 0);
		ecc_case(ECC_FLAGS, 9'd293, 8'd142, 1);
		ecc_case(ECC_CRC, 9'd3, 8'd143, 3);
		ecc_case(ECC_HDR, 9'd0, 8'd144, 0);
		ecc_case(ECC_EREG, 9'd0, 8'd145, 0);
		ecc_case(ECC_EREG, 9'd11, 8'd147, 3);
		$display("t_maps done");
	endtask : t_maps
	task automatic t_held_and_host;
		fb_case(FB_DATA, 12'h005, 12'h015);
		apb(1'b1, A_CTL, 32'h01);
		eng_u.fb_write(FB_DATA, 12'h005, 8'h00);
		apb(1'b1, A_CTL, 32'hC0);
		apb(1'b0, 18'h0_0054, 32'h0);
		`CHK(r[7:0], 8'h15 ^ 8'h5A)
		eng_u.fb_write(FB_HDR, 12'h001, 8'h00);
		apb(1'b0, {4'h0, 12'h00D, 2'b00}, 32'h0);
		`CHK(r[7:0], hh[15:8])
		eng_u.fb_write(FB_SUBHDR, 12'h000, 8'h00);
		apb(1'b0, {4'h0, 12'h010, 2'b00}, 32'h0);
		`CHK(r[7:0], hs[7:0])
		$display("t_held_and_host done");
	endtask : t_held_and_host
	task automatic t_freeze_reset;
		@(posedge clk_in);
		ce <= 1'b0;
		eng_u.eof_pulse();
		ce <= 1'b1;
		apb(1'b0, A_STAT, 32'h0);
		`CHK(r[7:0], 8'h00)
		eng_u.eof_pulse();
		apb(1'b0, A_STAT, 32'h0);
		`CHK(r[7:0], 8'h01)
		@(posedge clk_in);
		resetn_in <= 1'b0;
		repeat (3) @(posedge clk_in);
		resetn_in <= 1'b1;
		apb(1'b0, A_SSEL, 32'h0);
		`CHK(r, 32'h0000_0003)
		apb(1'b0, A_CTL, 32'h0);
		`CHK(r, 32'h0000_0000)
		`CHK({rst_o, grant_o, hsel_o, ssel_o}, 4'b0000)
		$display("t_freeze_reset done");
	endtask : t_freeze_reset
	initial begin
		repeat (10) @(posedge clk_in);
		resetn_in <= 1'b1;
		t_regs();
		t_status();
		t_maps();
		t_held_and_host();
		t_freeze_reset();
		close_out();
	end
	initial begin
		#1_000_000;
		miscompares++;
		close_out();
	end
endmodule : bencs_top_tb_top
